// *** logic/ssh_pkg.sv ***
package ssh_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned ST_W      = 16;
  localparam int unsigned CMD_W     = 16;
  localparam int unsigned ALERT_N   = 6;
  localparam int unsigned HTR_SEG_N = 14;
  localparam int unsigned SERIAL_W  = 48;

  // ==========================================================
  // Status word bit positions
  localparam int unsigned ST_ALERT_ANY = 15;
  localparam int unsigned ST_HEATER    = 13;
  localparam int unsigned ST_TRK_HI    = 11; // Humidity tracking alert
  localparam int unsigned ST_TRK_LO    = 6;  // Temperature low alert
  localparam int unsigned ST_RST_DET   = 4;
  localparam int unsigned ST_CRC_FAIL  = 0;
  localparam logic [15:0] ST_RSVD_MASK = 16'h502e;

  // ==========================================================
  // Serial identifier chunks, most significant first
  localparam int unsigned SER_HI_LSB  = 32; // Bytes 5 and 4
  localparam int unsigned SER_MID_LSB = 16; // Bytes 3 and 2
  localparam int unsigned SER_LO_LSB  = 0;  // Bytes 1 and 0
  localparam int unsigned SER_CHUNK_W = 16;

  // ==========================================================
  // Reset values
  localparam logic [13:0] HTR_CFG_RST  = 14'h3fff;
  localparam logic        ALERT_ANY_RST = 1'b1;
  localparam logic        RST_DET_RST   = 1'b1;

  // ==========================================================
  // Command codes as handed over by the bus front end
  localparam logic [15:0] CMD_STATUS_READ  = 16'h0001;
  localparam logic [15:0] CMD_STATUS_CLEAR = 16'h0002;
  localparam logic [15:0] CMD_HEATER_ON    = 16'h0003;
  localparam logic [15:0] CMD_HEATER_OFF   = 16'h0004;
  localparam logic [15:0] CMD_HEATER_CFG   = 16'h0005;
  localparam logic [15:0] CMD_SERIAL_HI    = 16'h0006;
  localparam logic [15:0] CMD_SERIAL_MID   = 16'h0007;
  localparam logic [15:0] CMD_SERIAL_LO    = 16'h0008;

  // Arbitrary neutral identifier value, replaced per part
  localparam logic [47:0] SERIAL_ID_DEF = 48'h0123_4567_89ab;
endpackage

// *** logic/ssh_sync.sv ***
`timescale 1ns/1ps
// Toggle synchroniser: two flops, then an edge flop giving a pulse
module ssh_sync (
  // Destination clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Toggle from the other domain and its local pulse
  input  wire logic tgl_in,
  output wire logic pls_out
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // Only sync_r reads meta_r
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= tgl_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // One pulse per toggle
  assign pls_out = sync_r ^ last_r;
endmodule

// *** logic/ssh_regs.sv ***
`timescale 1ns/1ps
// Operation
// - Status bit 15 shows any active alert, live; reset value 1 until the first clock.
// - Status bit 13 shows heater on or off; reset value 0.
// - Status bit 11 flags a humidity tracking alert; reset 0.
// - Status bit 10 flags a temperature tracking alert; reset 0.
// - Bits 9 and 8 flag humidity high and low alerts; reset 0.
// - Bits 7 and 6 flag temperature high and low alerts; reset 0.
// - Bit 4 set by any reset event, 1 at power-up, held till clear.
// - Bit 0 is 1 when the last data write had a bad checksum.
// - Commands read the status word and clear its alert, reset and checksum flags.
// - Heater-enable and heater-disable commands switch the heater.
// - Heater select word: two upper bits zero, fourteen segment enables.
// - A fixed unique 48-bit identifier is readable by the host.
// - Three commands each return two identifier bytes plus CRC.
// - Identifier chunks go out bytes 5,4 then 3,2 then 1,0.
module ssh_regs
  import ssh_pkg::*;
#(
  parameter logic [47:0] SERIAL_ID = SERIAL_ID_DEF
) (
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Alert conditions from the threshold logic
  input  wire logic        alert_rh_trk,
  input  wire logic        alert_t_trk,
  input  wire logic        alert_rh_high,
  input  wire logic        alert_rh_low,
  input  wire logic        alert_t_high,
  input  wire logic        alert_t_low,
  // Soft reset or supply failure seen elsewhere, one-cycle pulse
  input  wire logic        rst_event,
  // Link side, clocked by the bus front end
  input  wire logic        lnk_clk,
  input  wire logic        lnk_cmd_valid,
  input  wire logic [15:0] lnk_cmd_code,
  input  wire logic [15:0] lnk_wr_data,
  input  wire logic        lnk_wr_crc_ok,
  output logic             lnk_busy,
  output logic             lnk_rd_valid,
  output logic      [15:0] lnk_rd_data,
  // Heater drive
  output logic             heater_on,
  output logic      [13:0] heater_seg_en
);

  // ==========================================================
  // Link domain: command capture and answer return
  logic [15:0] lnk_cmd_r;
  logic [15:0] lnk_data_r;
  logic        lnk_crc_ok_r;
  logic        lnk_req_tgl_r;
  logic        lnk_ack_pls;
  logic        sys_ack_tgl_r;
  logic [15:0] sys_rd_word_r;

  // Capture a command; one in flight, later ones dropped while busy
  always_ff @(posedge lnk_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk_cmd_r     <= '0;
      lnk_data_r    <= '0;
      lnk_crc_ok_r  <= 1'b0;
      lnk_req_tgl_r <= 1'b0;
    end else if (lnk_cmd_valid && !lnk_busy) begin
      lnk_cmd_r     <= lnk_cmd_code;
      lnk_data_r    <= lnk_wr_data;
      lnk_crc_ok_r  <= lnk_wr_crc_ok;
      lnk_req_tgl_r <= ~lnk_req_tgl_r;
    end
  end

  // Busy from capture until the system side answers
  always_ff @(posedge lnk_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk_busy <= 1'b0;
    end else if (lnk_cmd_valid && !lnk_busy) begin
      lnk_busy <= 1'b1;
    end else if (lnk_ack_pls) begin
      lnk_busy <= 1'b0;
    end
  end

  // Answer word is stable here: the system side holds it until
  // the next request, which cannot come before this pulse
  always_ff @(posedge lnk_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk_rd_valid <= 1'b0;
      lnk_rd_data  <= '0;
    end else begin
      lnk_rd_valid <= lnk_ack_pls;
      if (lnk_ack_pls) begin
        lnk_rd_data <= sys_rd_word_r;
      end
    end
  end

  ssh_sync u_ack_sync (
    .clk     (lnk_clk),
    .rst_b   (rst_b),
    .tgl_in  (sys_ack_tgl_r),
    .pls_out (lnk_ack_pls)
  );

  // ==========================================================
  // System domain: command decode
  logic       cmd_pls;
  logic       is_rd_status;
  logic       is_clear;
  logic       is_htr_on;
  logic       is_htr_off;
  logic       is_htr_cfg;
  logic       is_ser_hi;
  logic       is_ser_mid;
  logic       is_ser_lo;

  ssh_sync u_req_sync (
    .clk     (sys_clk),
    .rst_b   (rst_b),
    .tgl_in  (lnk_req_tgl_r),
    .pls_out (cmd_pls)
  );

  // Link registers are held while busy, so reading them here is safe
  always_comb begin
    is_rd_status = 1'b0;
    is_clear     = 1'b0;
    is_htr_on    = 1'b0;
    is_htr_off   = 1'b0;
    is_htr_cfg   = 1'b0;
    is_ser_hi    = 1'b0;
    is_ser_mid   = 1'b0;
    is_ser_lo    = 1'b0;
    case (lnk_cmd_r)
      CMD_STATUS_READ:  is_rd_status = cmd_pls;
      CMD_STATUS_CLEAR: is_clear     = cmd_pls;
      CMD_HEATER_ON:    is_htr_on    = cmd_pls;
      CMD_HEATER_OFF:   is_htr_off   = cmd_pls;
      CMD_HEATER_CFG:   is_htr_cfg   = cmd_pls;
      CMD_SERIAL_HI:    is_ser_hi    = cmd_pls;
      CMD_SERIAL_MID:   is_ser_mid   = cmd_pls;
      CMD_SERIAL_LO:    is_ser_lo    = cmd_pls;
      default: ; // Unknown codes are answered with zero
    endcase
  end

  // ==========================================================
  // Status flags
  logic [ALERT_N-1:0] alert_cond;
  logic [ALERT_N-1:0] alert_lat_r;
  logic               alert_any_r;
  logic               heater_on_r;
  logic               rst_det_r;
  logic               crc_fail_r;
  logic [13:0]        heater_cfg_r;
  logic [ST_W-1:0]    status_word;

  // Ordered to match status bits 11 down to 6
  assign alert_cond = {alert_rh_trk, alert_t_trk,
                       alert_rh_high, alert_rh_low,
                       alert_t_high, alert_t_low};

  // Summary follows live conditions; starts high until first sample
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_any_r <= ALERT_ANY_RST;
    end else begin
      alert_any_r <= |alert_cond;
    end
  end

  // Latched alerts: a condition present during clear survives it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_lat_r <= '0;
    end else if (is_clear) begin
      alert_lat_r <= alert_cond;
    end else begin
      alert_lat_r <= alert_lat_r | alert_cond;
    end
  end

  // Reset detected: hard reset, soft reset or supply fail
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_det_r <= RST_DET_RST;
    end else if (rst_event) begin
      rst_det_r <= 1'b1;
    end else if (is_clear) begin
      rst_det_r <= 1'b0;
    end
  end

  // Checksum result of the latest data write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      crc_fail_r <= 1'b0;
    end else if (is_htr_cfg) begin
      crc_fail_r <= ~lnk_crc_ok_r;
    end else if (is_clear) begin
      crc_fail_r <= 1'b0;
    end
  end

  // ==========================================================
  // Heater control
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      heater_on_r <= 1'b0;
    end else if (is_htr_on) begin
      heater_on_r <= 1'b1;
    end else if (is_htr_off) begin
      heater_on_r <= 1'b0;
    end
  end

  // A write with a bad checksum leaves the old selection in place;
  // the two upper data bits are dropped since they must be zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      heater_cfg_r <= HTR_CFG_RST;
    end else if (is_htr_cfg && lnk_crc_ok_r) begin
      heater_cfg_r <= lnk_data_r[HTR_SEG_N-1:0];
    end
  end

  // Segment drive: bit n enables resistor segment n
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      heater_on     <= 1'b0;
      heater_seg_en <= '0;
    end else begin
      heater_on     <= heater_on_r;
      heater_seg_en <= heater_on_r ? heater_cfg_r : '0;
    end
  end

  // ==========================================================
  // Status word assembly; reserved bits stay zero
  always_comb begin
    status_word                        = '0;
    status_word[ST_ALERT_ANY]          = alert_any_r;
    status_word[ST_HEATER]             = heater_on_r;
    status_word[ST_TRK_HI:ST_TRK_LO]   = alert_lat_r;
    status_word[ST_RST_DET]            = rst_det_r;
    status_word[ST_CRC_FAIL]           = crc_fail_r;
  end

  // ==========================================================
  // Answer word and acknowledge toggle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_rd_word_r <= '0;
    end else if (cmd_pls) begin
      if (is_rd_status) begin
        sys_rd_word_r <= status_word;
      end else if (is_ser_hi) begin
        sys_rd_word_r <= SERIAL_ID[SER_HI_LSB +: SER_CHUNK_W];
      end else if (is_ser_mid) begin
        sys_rd_word_r <= SERIAL_ID[SER_MID_LSB +: SER_CHUNK_W];
      end else if (is_ser_lo) begin
        sys_rd_word_r <= SERIAL_ID[SER_LO_LSB +: SER_CHUNK_W];
      end else begin
        sys_rd_word_r <= '0;
      end
    end
  end

  // Every command is acknowledged, writes included
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_ack_tgl_r <= 1'b0;
    end else if (cmd_pls) begin
      sys_ack_tgl_r <= ~sys_ack_tgl_r;
    end
  end

  // ==========================================================
  // Checks
  sequence s_accept;
    lnk_cmd_valid && !lnk_busy;
  endsequence

  // Busy drops on the edge that raises the answer, so a request given
  // in the answer cycle may raise busy again right after it
  sequence s_answer;
    ##[2:6] (lnk_rd_valid && !lnk_busy) ##1 !lnk_rd_valid;
  endsequence

  chk_link_round_trip: assert property (
    @(posedge lnk_clk) disable iff (!rst_b)
    s_accept |-> s_answer
  ) else $error("link answer missing or late");

  // First edge after release still shows the reset value of the summary
  chk_alert_summary: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $past(rst_b) |-> status_word[ST_ALERT_ANY] == |$past(alert_cond)
  ) else $error("alert summary does not follow conditions");

  chk_heater_enable: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    is_htr_on |=> status_word[ST_HEATER] ##1 heater_on
  ) else $error("heater did not switch on");

  chk_heater_disable: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    is_htr_off |=> !status_word[ST_HEATER] ##1
                   (!heater_on && heater_seg_en == '0)
  ) else $error("heater did not switch off");

  chk_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (status_word & ST_RSVD_MASK) == '0
  ) else $error("reserved status bit set");

  chk_rst_det_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(rst_det_r) |-> $past(is_clear) && !$past(rst_event)
  ) else $error("reset flag dropped without clear");

  chk_crc_flag: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    is_htr_cfg |=> crc_fail_r == !$past(lnk_crc_ok_r)
  ) else $error("checksum flag wrong after write");

  chk_clear_status: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    is_clear && !rst_event && alert_cond == '0 |=>
      !rst_det_r && !crc_fail_r && alert_lat_r == '0
  ) else $error("clear left a flag set");

  chk_alert_latch: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (|($past(alert_lat_r) & ~alert_lat_r)) |-> $past(is_clear)
  ) else $error("alert flag dropped without clear");

  chk_serial_order: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    is_ser_hi |=> sys_rd_word_r == SERIAL_ID[47:32]
  ) else $error("first serial chunk is not bytes 5 and 4");

  chk_heater_cfg: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    is_htr_cfg && lnk_crc_ok_r |=>
      heater_cfg_r == $past(lnk_data_r[13:0])
  ) else $error("heater selection not stored");
endmodule

// *** dv/ssh_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Bus front end model: issues one link command at a time
module ssh_host_model (
  // Link clock made here
  output logic        lnk_clk,
  // Command side
  output logic        lnk_cmd_valid,
  output logic [15:0] lnk_cmd_code,
  output logic [15:0] lnk_wr_data,
  output logic        lnk_wr_crc_ok,
  // Answer side
  input  wire logic        lnk_busy,
  input  wire logic        lnk_rd_valid,
  input  wire logic [15:0] lnk_rd_data
);
  // Phase offset keeps this clock unrelated to the system clock
  initial begin
    lnk_clk = 1'b0;
    #3;
    forever #80 lnk_clk = ~lnk_clk;
  end

  initial begin
    lnk_cmd_valid = 1'b0;
    lnk_cmd_code  = 16'h0000;
    lnk_wr_data   = 16'h0000;
    lnk_wr_crc_ok = 1'b1;
  end

  // One command, then wait a bounded time for its answer
  task automatic xfer(input logic [15:0] code, input logic [15:0] data,
                      input logic crc, input logic [15:0] intr,
                      output logic [15:0] rd, output logic bsy,
                      output bit ok);
    int n;
    n = 0;
    ok = 0;
    rd = 16'h0000;
    @(negedge lnk_clk);
    lnk_cmd_valid = 1'b1;
    lnk_cmd_code  = code;
    lnk_wr_data   = data;
    lnk_wr_crc_ok = crc;
    @(negedge lnk_clk);
    // Taken at the edge just passed, so busy must stand now
    bsy = lnk_busy;
    // Keep valid one more cycle with another code: it must be refused
    lnk_cmd_code  = intr;
    lnk_wr_data   = ~data;
    @(negedge lnk_clk);
    // Scramble the idle qualifiers so stale values never look valid
    lnk_cmd_valid = 1'b0;
    lnk_cmd_code  = ~code;
    lnk_wr_data   = ~data;
    while (n < 10 && !ok) begin
      if (lnk_rd_valid === 1'b1) begin
        ok = 1;
        rd = lnk_rd_data;
      end else begin
        @(negedge lnk_clk);
      end
      n++;
    end
  endtask
endmodule

// *** dv/ssh_regs_tb.sv ***
`timescale 1ns/1ps
module ssh_regs_tb;
  import ssh_pkg::*;
  logic        sys_clk, rst_b, rst_event;
  logic [5:0]  alerts;
  logic        lnk_clk, lnk_cmd_valid, lnk_wr_crc_ok, lnk_busy;
  logic        lnk_rd_valid, heater_on;
  logic [15:0] lnk_cmd_code, lnk_wr_data, lnk_rd_data, rd;
  logic [13:0] heater_seg_en, cfg;
  logic [5:0]  lat;
  logic        htr, rdet, crcf;
  logic [31:0] seed;
  logic [15:0] tbl [4];
  int          bad_count, n_tests;

  // ==========================================================
  // Clock, design and far side
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;

  ssh_regs i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .alert_rh_trk(alerts[5]), .alert_t_trk(alerts[4]),
    .alert_rh_high(alerts[3]), .alert_rh_low(alerts[2]),
    .alert_t_high(alerts[1]), .alert_t_low(alerts[0]),
    .rst_event(rst_event), .lnk_clk(lnk_clk),
    .lnk_cmd_valid(lnk_cmd_valid), .lnk_cmd_code(lnk_cmd_code),
    .lnk_wr_data(lnk_wr_data), .lnk_wr_crc_ok(lnk_wr_crc_ok),
    .lnk_busy(lnk_busy), .lnk_rd_valid(lnk_rd_valid),
    .lnk_rd_data(lnk_rd_data), .heater_on(heater_on),
    .heater_seg_en(heater_seg_en));

  ssh_host_model i_host (
    .lnk_clk(lnk_clk), .lnk_cmd_valid(lnk_cmd_valid),
    .lnk_cmd_code(lnk_cmd_code), .lnk_wr_data(lnk_wr_data),
    .lnk_wr_crc_ok(lnk_wr_crc_ok), .lnk_busy(lnk_busy),
    .lnk_rd_valid(lnk_rd_valid), .lnk_rd_data(lnk_rd_data));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Expected status word from the tracked state; reserved bits zero
  function automatic logic [15:0] exp_st();
    return {|alerts, 1'b0, htr, 1'b0, lat, 1'b0, rdet, 3'b000, crcf};
  endfunction

  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_h(input logic [13:0] exp);
    n_tests++;
    if ({heater_on, heater_seg_en} !== {htr, exp}) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time,
               {heater_on, heater_seg_en}, {htr, exp});
    end
  endtask

  task automatic cmd(input logic [15:0] code, input logic [15:0] data,
                     input logic crc);
    bit   ok;
    logic bsy;
    // A clear slipped in while busy would wipe flags if taken
    i_host.xfer(code, data, crc, CMD_STATUS_CLEAR, rd, bsy, ok);
    chk_w({15'h0000, bsy}, 16'h0001);
    if (!ok) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
  endtask

  task automatic rd_st();
    cmd(CMD_STATUS_READ, 16'h0000, 1'b1);
    chk_w(rd, exp_st());
  endtask

  // Settle time for system-side effects after an answer
  task automatic settle();
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog sized well above the expected run
  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0; rst_event = 1'b0; alerts = 6'h00;
    bad_count = 0; n_tests = 0; seed = 32'd62804;
    lat = 6'h00; htr = 1'b0; rdet = 1'b1; crcf = 1'b0; cfg = 14'h3fff;
    tbl = '{16'h3fff, 16'h03ff, 16'h009f, 16'h0000};
    // Both clocks must see the reset, so count the slow one
    repeat (3) @(negedge lnk_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(posedge lnk_clk);
    rd_st();
    chk_h(14'h0000);
    cmd(CMD_STATUS_CLEAR, 16'h0000, 1'b1);
    rdet = 1'b0;
    rd_st();
    // One alert at a time: live summary bit, then latched flag
    for (int i = 0; i < 6; i++) begin
      @(negedge sys_clk);
      alerts = 6'h01 << i;
      lat = lat | alerts;
      settle();
      rd_st();
      @(negedge sys_clk);
      alerts = 6'h00;
      settle();
      rd_st();
      cmd(CMD_STATUS_CLEAR, 16'h0000, 1'b1);
      lat = 6'h00;
      rd_st();
    end
    // Clear while conditions stand: the set wins
    @(negedge sys_clk);
    alerts = 6'h24;
    lat = 6'h24;
    cmd(CMD_STATUS_CLEAR, 16'h0000, 1'b1);
    rd_st();
    // Random alert mixes with reset events, the first one forced
    for (int i = 0; i < 6; i++) begin
      seed = xorshift(seed);
      @(negedge sys_clk);
      alerts = seed[5:0];
      rst_event = seed[6] | (i == 0);
      lat = lat | alerts;
      rdet = rdet | rst_event;
      @(negedge sys_clk);
      rst_event = 1'b0;
      settle();
      rd_st();
      @(negedge sys_clk);
      alerts = 6'h00;
      cmd(CMD_STATUS_CLEAR, 16'h0000, 1'b1);
      lat = 6'h00;
      rdet = 1'b0;
    end
    // Heater selections, bad checksum, enable and disable
    seed = xorshift(seed);
    tbl[3] = seed[15:0];
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_HEATER_CFG, tbl[i], 1'b1);
      cfg = tbl[i][13:0];
      crcf = 1'b0;
      cmd(CMD_HEATER_ON, 16'h0000, 1'b1);
      htr = 1'b1;
      settle();
      chk_h(cfg);
      rd_st();
      cmd(CMD_HEATER_CFG, ~tbl[i], 1'b0);
      crcf = 1'b1;
      settle();
      chk_h(cfg);
      rd_st();
      cmd(CMD_HEATER_OFF, 16'h0000, 1'b1);
      htr = 1'b0;
      settle();
      chk_h(14'h0000);
      rd_st();
    end
    // Identifier chunks, most significant first
    for (int k = 0; k < 3; k++) begin
      cmd(CMD_SERIAL_HI + 16'(k), 16'h0000, 1'b1);
      chk_w(rd, SERIAL_ID_DEF[47 - 16 * k -: 16]);
    end
    cmd(16'h00ff, 16'h0000, 1'b1);
    chk_w(rd, 16'h0000);
    summarize();
  end
endmodule
